// *** hdl/fpe_cpu.sv ***
// Controller end: AHB-Lite registers and timed program/erase sequences
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module fpe_cpu
  import fpe_pkg::*;
#(
  parameter logic [18:0] ERASE_CYC = 19'(C_ERASE),
  parameter logic [18:0] MERASE_CYC = 19'(C_MERASE),
  parameter logic [18:0] NVHL_CYC = 19'(C_NVHL)
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Array side
  fpe_if.cpu bus
);

  typedef enum logic [4:0] {
    H_IDLE, H_SEL, H_RDP, H_ARM, H_HV, H_CHK, H_EVAL, H_DAT, H_CLR,
    H_OFF, H_FIN, H_RD, H_RDC, H_STOP
  } fpe_hst_e;

  typedef struct packed {
    fpe_hst_e st;
    logic [18:0] cnt;
    fpe_op_e op;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] rdbyte;
    logic done;
    logic fail;
    logic dv;
    logic dwr;
    logic [3:0] doff;
    logic rdy;
    logic resp;
    logic [31:0] hrdata;
    logic [15:0] baddr;
    logic [7:0] bwdata;
    logic bwr;
    logic brd;
    logic bstop;
  } fpe_cpu_s;

  fpe_cpu_s r;
  fpe_cpu_s n;

  function automatic logic [7:0] selv(input fpe_op_e op);
    case (op)
      OP_PROG: selv = 8'h01 << PGM_BIT;
      OP_MASS: selv = (8'h01 << ERASE_BIT) | (8'h01 << MASS_BIT);
      default: selv = 8'h01 << ERASE_BIT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0] stat;
    stat = {16'h0000, r.rdbyte, 5'h00, r.fail, r.done, r.st != H_IDLE};
    n = r;
    n.bwr = 1'b0;
    n.brd = 1'b0;
    n.bstop = 1'b0;
    n.rdy = 1'b1;
    n.dv = hsel && hready && htrans[1] && hsize == 3'b010;
    n.dwr = hwrite;
    n.doff = haddr[3:0];
    case (haddr[3:0])
      REG_ADDR: n.hrdata = {16'h0000, r.addr};
      REG_DATA: n.hrdata = {24'h000000, r.data};
      REG_STAT: n.hrdata = stat;
      default: n.hrdata = 32'h00000000;
    endcase
    if (r.dv && r.dwr) begin
      case (r.doff)
        REG_ADDR: n.addr = hwdata[15:0];
        REG_DATA: n.data = hwdata[7:0];
        REG_STAT: if (hwdata[ST_DONE]) n.done = 1'b0;
        REG_CMD: if (r.st == H_IDLE) begin
          n.op = fpe_op_e'(hwdata[2:0]);
          n.fail = 1'b0;
          n.cnt = 19'h0;
          case (fpe_op_e'(hwdata[2:0]))
            OP_PROG, OP_PAGE, OP_MASS: n.st = H_SEL;
            OP_READ: n.st = H_RD;
            OP_STOP: n.st = H_STOP;
            default: n.st = H_IDLE;
          endcase
        end
        default: n.st = n.st;
      endcase
    end
    if (r.st != H_IDLE && r.cnt != 19'h0) begin
      n.cnt = r.cnt - 19'h1;
    end else begin
      case (r.st)
        H_SEL: begin
          n.bwr = 1'b1;
          n.baddr = CTRL_ADDR;
          n.bwdata = selv(r.op);
          n.st = H_RDP;
          n.cnt = 19'h1;
        end
        H_RDP: begin
          n.brd = 1'b1;
          n.baddr = PROT_ADDR;
          n.st = H_ARM;
          n.cnt = 19'h2;
        end
        H_ARM: begin
          n.bwr = 1'b1;
          n.baddr = r.addr;
          n.bwdata = r.data;
          n.st = H_HV;
          n.cnt = 19'(C_NVS);
        end
        H_HV: begin
          n.bwr = 1'b1;
          n.baddr = CTRL_ADDR;
          n.bwdata = selv(r.op) | (8'h01 << HV_BIT);
          n.st = H_CHK;
          n.cnt = 19'h1;
        end
        H_CHK: begin
          n.brd = 1'b1;
          n.baddr = CTRL_ADDR;
          n.st = H_EVAL;
          n.cnt = 19'h2;
        end
        H_EVAL: begin
          if (!bus.rdata[HV_BIT]) begin
            n.fail = 1'b1;
            n.st = H_OFF;
            n.cnt = 19'h0;
          end else if (r.op == OP_PROG) begin
            n.st = H_DAT;
            n.cnt = 19'(C_PGS);
          end else begin
            n.st = H_CLR;
            n.cnt = r.op == OP_MASS ? MERASE_CYC : ERASE_CYC;
          end
        end
        H_DAT: begin
          n.bwr = 1'b1;
          n.baddr = r.addr;
          n.bwdata = r.data;
          n.st = H_CLR;
          n.cnt = 19'(C_PROG);
        end
        H_CLR: begin
          n.bwr = 1'b1;
          n.baddr = CTRL_ADDR;
          n.bwdata = 8'h01 << HV_BIT;
          n.st = H_OFF;
          n.cnt = r.op == OP_MASS ? NVHL_CYC : 19'(C_NVH);
        end
        H_OFF: begin
          n.bwr = 1'b1;
          n.baddr = CTRL_ADDR;
          n.bwdata = 8'h00;
          n.st = H_FIN;
          n.cnt = 19'(C_RCV);
        end
        H_RD: begin
          n.brd = 1'b1;
          n.baddr = r.addr;
          n.st = H_RDC;
          n.cnt = 19'h2;
        end
        H_RDC: begin
          n.rdbyte = bus.rdata;
          n.st = H_FIN;
        end
        H_STOP: begin
          n.bstop = 1'b1;
          n.st = H_FIN;
        end
        H_FIN: begin
          n.done = 1'b1;
          n.st = H_IDLE;
        end
        H_IDLE: n.st = n.st;
        default: n.st = H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.rdy;
  assign hresp = r.resp;
  assign hrdata = r.hrdata;
  assign bus.addr = r.baddr;
  assign bus.wdata = r.bwdata;
  assign bus.wr = r.bwr;
  assign bus.rd = r.brd;
  assign bus.stop = r.bstop;

endmodule // fpe_cpu

// *** hdl/fpe_pkg.sv ***
// Shared constants, types and helpers for the flash program/erase pair
package fpe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Device map
  localparam logic [15:0] CTRL_ADDR = 16'hfe08;
  localparam logic [15:0] PROT_ADDR = 16'hff7e;
  localparam logic [7:0] NO_ARRAY_HI = 8'hfe;
  localparam int MEM_BYTES = 32768;
  localparam logic [14:0] PROT_IDX = 15'h7f7e;
  localparam logic [14:0] PAGE_LAST = 15'h007f;
  localparam logic [14:0] MASS_LAST = 15'h7fff;
  localparam logic [7:0] BPR_ALL = 8'h00;
  localparam logic [7:0] BPR_NONE = 8'hff;
  localparam logic [7:0] ERASED = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int PGM_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int MASS_BIT = 2;
  localparam int HV_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Controller register map and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RD_LSB = 8;

  typedef enum logic [2:0] {
    OP_NONE, OP_PROG, OP_PAGE, OP_MASS, OP_READ, OP_STOP
  } fpe_op_e;

  typedef enum logic [1:0] {D_IDLE, D_SEL, D_ARMED, D_LATCH} fpe_dst_e;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 10;
  localparam int T_NVS_NS = 10000;
  localparam int T_ERASE_NS = 1000000;
  localparam int T_MERASE_NS = 4000000;
  localparam int T_NVH_NS = 5000;
  localparam int T_NVHL_NS = 100000;
  localparam int T_PGS_NS = 5000;
  localparam int T_PROG_NS = 30000;
  localparam int T_RCV_NS = 1000;
  localparam int C_NVS = (T_NVS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_ERASE = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_MERASE = (T_MERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_NVH = (T_NVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_NVHL = (T_NVHL_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_PGS = (T_PGS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_PROG = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RCV = (T_RCV_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic in_array(input logic [15:0] a);
    return a[15] && (a[15:8] != NO_ARRAY_HI);
  endfunction

  function automatic logic blocked(input logic [15:0] a,
                                   input logic [7:0] bpr,
                                   input logic mass, input logic tv);
    if (tv || bpr == BPR_NONE)
      return 1'b0;
    if (mass || bpr == BPR_ALL)
      return 1'b1;
    return a >= {1'b1, bpr, 7'h00};
  endfunction

endpackage

// *** hdl/fpe_if.sv ***
// Processor-to-array bus between controller and flash array
`timescale 1ns/1ns
interface fpe_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic stop;
  logic [7:0] rdata;

  modport nvm (input addr, input wdata, input wr, input rd, input stop,
               output rdata);
  modport cpu (output addr, output wdata, output wr, output rd,
               output stop, input rdata);
endinterface

// *** hdl/fpe_nvm.sv ***
// Array end: control register, arming, protection and array storage
// Function
// - Erased bits read one, programmed read zero
// - Pages of 128 bytes, rows of 64
// - Pump enable only after proper selected sequence
// - Whole-array select widens erase to all
// - Program and erase selects never both set
// - Page erase: select, read protect, write, wait
// - Hold pump 1 ms, then timed teardown
// - Whole-array erase holds 4 ms, 100 us
// - Failed security: arm at protect byte location
// - Program select latches address of array writes
// - Program: arm, wait, pump on, settle
// - Each byte waits 30 us, then teardown
// - Row is 64 aligned bytes
// - Byte intervals stay under the maximum
// - Sequence code runs outside the array
// - Steps strictly in order
// - Protect read after select arms operation
// - Protected target refuses pump enable
// - Zeros protect all, ones protect none
// - Programmed protect byte locks itself too
// - Protect start is one, boundary, zeros
// - Protect byte lives in array, survives reset
// - Stop aborts operation into standby
`timescale 1ns/1ns
module fpe_nvm
  import fpe_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Processor side
  fpe_if.nvm bus,
  // Test voltage pin
  input wire logic test_hv,
  // Status
  output logic pump_on,
  output logic standby
);

  typedef struct packed {
    fpe_dst_e st;
    logic hv;
    logic mass;
    logic erase;
    logic write_select;
    logic [15:0] tgt;
    logic [7:0] rdata;
    logic sweep;
    logic [14:0] cnt;
    logic sync1;
    logic sync2;
    logic standby;
  } fpe_nvm_s;

  fpe_nvm_s r;
  fpe_nvm_s n;
  logic [7:0] mem [MEM_BYTES] = '{default: ERASED};
  logic mem_we;
  logic [14:0] mem_idx;
  logic [7:0] mem_wd;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic ctrl_hit(input logic [15:0] a);
    return a == CTRL_ADDR;
  endfunction

  function automatic logic prot_hit(input logic [15:0] a);
    return a == PROT_ADDR;
  endfunction

  function automatic logic same_row(input logic [15:0] a,
                                    input logic [15:0] b);
    return a[15:6] == b[15:6];
  endfunction

  function automatic logic [14:0] sweep_last(input logic mass);
    return mass ? MASS_LAST : PAGE_LAST;
  endfunction

  function automatic logic [7:0] ctrl_byte(input fpe_nvm_s s);
    return {4'h0, s.hv, s.mass, s.erase, s.write_select};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] bpr;
    logic grant;
    bpr = mem[PROT_IDX];
    grant = 1'b0;
    n = r;
    n.sync1 = test_hv;
    n.sync2 = r.sync1;
    mem_we = 1'b0;
    mem_idx = r.tgt[14:0];
    mem_wd = ERASED;

    // Erase sweep, one byte per cycle
    if (r.sweep) begin
      mem_we = 1'b1;
      if (r.mass) begin
        mem_idx = r.cnt;
      end else begin
        mem_idx = {r.tgt[14:7], r.cnt[6:0]};
      end
      n.cnt = r.cnt + 15'h1;
      if (r.cnt == sweep_last(r.mass)) begin
        n.sweep = 1'b0;
      end
    end

    // Reads
    if (bus.rd) begin
      n.standby = 1'b0;
      if (ctrl_hit(bus.addr)) begin
        n.rdata = ctrl_byte(r);
      end else if (in_array(bus.addr)) begin
        n.rdata = mem[bus.addr[14:0]];
      end else begin
        n.rdata = 8'h00;
      end
      if (prot_hit(bus.addr) && r.st == D_SEL) begin
        n.st = D_ARMED;
      end
    end

    // Control register writes
    if (bus.wr && ctrl_hit(bus.addr)) begin
      n.standby = 1'b0;
      if (!(bus.wdata[PGM_BIT] && bus.wdata[ERASE_BIT])) begin
        n.write_select = bus.wdata[PGM_BIT];
        n.erase = bus.wdata[ERASE_BIT];
      end
      n.mass = bus.wdata[MASS_BIT];
      if ((n.write_select && !r.write_select) || (n.erase && !r.erase)) begin
        n.st = D_SEL;
      end else if (!n.write_select && !n.erase) begin
        n.st = D_IDLE;
      end
      grant = !r.hv && (n.write_select || n.erase) && r.st == D_LATCH
        && n.st == D_LATCH;
      if (blocked(r.tgt, bpr, n.mass, r.sync2)) begin
        grant = 1'b0;
      end
      if (!bus.wdata[HV_BIT]) begin
        n.hv = 1'b0;
        n.sweep = 1'b0;
      end else if (grant) begin
        n.hv = 1'b1;
        n.sweep = n.erase;
        n.cnt = 15'h0000;
      end
      if (!n.erase) begin
        n.sweep = 1'b0;
      end

    // Array writes
    end else if (bus.wr && in_array(bus.addr)) begin
      n.standby = 1'b0;
      if (r.st == D_ARMED) begin
        n.tgt = bus.addr;
        n.st = D_LATCH;
      end else if (r.hv && r.write_select && r.st == D_LATCH
                   && same_row(bus.addr, r.tgt)) begin
        mem_we = 1'b1;
        mem_idx = bus.addr[14:0];
        mem_wd = mem[bus.addr[14:0]] & bus.wdata;
      end
    end

    // Stop request aborts and parks the array
    if (bus.stop) begin
      n.hv = 1'b0;
      n.write_select = 1'b0;
      n.erase = 1'b0;
      n.mass = 1'b0;
      n.sweep = 1'b0;
      n.st = D_IDLE;
      n.standby = 1'b1;
      mem_we = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array storage, no reset
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus.rdata = r.rdata;
  assign pump_on = r.hv;
  assign standby = r.standby;

endmodule // fpe_nvm

// *** verif/fpe_link_chk.sv ***
// Checker for the controller-to-array link
`timescale 1ns/1ns
module fpe_link_chk
  import fpe_pkg::*;
#(
  parameter int NVH_MIN = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic stop,
  input wire logic [7:0] rdata,
  // Array pins
  input wire logic test_hv,
  input wire logic pump_on,
  input wire logic standby
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////
  // Helper state
  logic cw;
  logic hvw, prd, prd_q, mass_q;
  logic [7:0] bpr_q;
  logic [15:0] tgt_q, gap, hold;
  assign cw = wr && addr == CTRL_ADDR;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hvw <= 1'b0;
      prd <= 1'b0;
      prd_q <= 1'b0;
      mass_q <= 1'b0;
      bpr_q <= 8'h00;
      tgt_q <= 16'h0000;
      gap <= 16'h0000;
      hold <= 16'h0000;
    end else begin
      hvw <= cw && wdata[HV_BIT];
      prd_q <= rd && addr == PROT_ADDR;
      if (prd_q) bpr_q <= rdata;
      if (rd && addr == PROT_ADDR) prd <= 1'b1;
      else if (cw && !wdata[HV_BIT]) prd <= 1'b0;
      if (cw && (wdata[PGM_BIT] || wdata[ERASE_BIT])) mass_q <= wdata[MASS_BIT];
      if (wr && !cw) tgt_q <= addr;
      gap <= (wr && !cw) ? 16'h0000 : gap + {15'h0000, gap != 16'hffff};
      hold <= (cw && wdata == 8'h08) ? 16'h0000
            : hold + {15'h0000, hold != 16'hffff};
    end
  end
  //////////////////////////////////////////////////////////////
  // Properties
  property p_hv_cause;
    $rose(pump_on) |-> hvw;
  endproperty
  a_hv_cause: assert property (p_hv_cause)
    else $error("pump on without enable write");
  property p_sel_excl;
    rd && addr == CTRL_ADDR |=> !(rdata[PGM_BIT] && rdata[ERASE_BIT]);
  endproperty
  a_sel_excl: assert property (p_sel_excl)
    else $error("program and erase select both read set");
  property p_arm;
    $rose(pump_on) |-> prd;
  endproperty
  a_arm: assert property (p_arm)
    else $error("pump on without protect read");
  property p_setup;
    $rose(pump_on) |-> gap >= 16'(C_NVS);
  endproperty
  a_setup: assert property (p_setup)
    else $error("pump on too soon after arming write");
  property p_hold;
    $fell(pump_on) && !$past(stop)
      |-> hold >= (mass_q ? 16'(NVH_MIN) : 16'(C_NVH));
  endproperty
  a_hold: assert property (p_hold)
    else $error("pump off too soon after select cleared");
  property p_prot;
    $rose(pump_on) |-> test_hv || bpr_q == BPR_NONE
      || (!mass_q && bpr_q != BPR_ALL && tgt_q < {1'b1, bpr_q, 7'h00});
  endproperty
  a_prot: assert property (p_prot)
    else $error("pump on for protected target");
  property p_stop;
    stop |=> standby && !pump_on;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not abort into standby");
  property p_sby;
    standby && (wr || rd) && !stop |=> !standby;
  endproperty
  a_sby: assert property (p_sby)
    else $error("standby kept after access");
  c_pump: cover property ($rose(pump_on));
  c_stop: cover property (stop);
  c_prot: cover property (rd && addr == PROT_ADDR);
endmodule // fpe_link_chk

// *** verif/flash_program_erase_ctrl_bench.sv ***
// Bench for the controller and array pair
`timescale 1ns/1ns
module flash_program_erase_ctrl_bench
  import fpe_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic test_hv = 1'b0;
  logic hready, hreadyout, hresp, pump_on, standby;
  logic [31:0] hrdata;
  int err_total = 0;
  int check_count = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  //////////////////////////////////////////////////////////////
  // Design pair and checker
  fpe_if lk();
  fpe_cpu #(.ERASE_CYC(19'h000c8), .MERASE_CYC(19'h080e8),
    .NVHL_CYC(19'h00014))
    fpe_cpu_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bus(lk));
  fpe_nvm fpe_nvm_i(.hclk(hclk), .hresetn(hresetn), .bus(lk),
    .test_hv(test_hv), .pump_on(pump_on), .standby(standby));
  fpe_link_chk #(.NVH_MIN(20)) fpe_link_chk_i(.hclk(hclk),
    .hresetn(hresetn), .addr(lk.addr), .wdata(lk.wdata), .wr(lk.wr),
    .rd(lk.rd), .stop(lk.stop), .rdata(lk.rdata), .test_hv(test_hv),
    .pump_on(pump_on), .standby(standby));
  //////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ps(input logic [7:0] p);
    return {1'b1, p, 7'h00};
  endfunction
  function automatic logic [7:0] pv(input logic [7:0] o, input logic [7:0] n);
    return o & n;
  endfunction
  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic op(input logic [2:0] c, input logic [15:0] a,
                    input logic [7:0] d, input logic f, output logic [7:0] b);
    logic [31:0] r;
    logic fl;
    ahb(1'b1, REG_ADDR, {16'h0, a}, r);
    ahb(1'b1, REG_DATA, {24'h0, d}, r);
    ahb(1'b1, REG_CMD, {29'h0, c}, r);
    do ahb(1'b0, REG_STAT, 32'h0, r); while (r[ST_DONE] !== 1'b1);
    b = r[15:8];
    fl = r[ST_FAIL];
    ahb(1'b1, REG_STAT, 32'h2, r);
    chk({31'h0, fl}, {31'h0, f});
  endtask
  task automatic rdb(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] b;
    op(OP_READ, a, 8'h00, 1'b0, b);
    chk({24'h0, b}, {24'h0, e});
  endtask
  //////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    logic [15:0] s, a;
    logic [7:0] d, e, b;
    logic [31:0] r;
    s = 16'hc6e1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, REG_STAT, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rdb(16'h8000, ERASED);
    repeat (2) begin
      s = nx(s);
      a = {2'b10, s[13:0]};
      s = nx(s);
      d = s[7:0];
      e = s[15:8];
      op(OP_PROG, a, d, 1'b0, b);
      op(OP_PROG, a, e, 1'b0, b);
      rdb(a, pv(pv(ERASED, d), e));
      op(OP_PAGE, a, 8'h00, 1'b0, b);
      rdb(a, ERASED);
      rdb({a[15:7], ~a[6:0]}, ERASED);
    end
    ahb(1'b1, REG_ADDR, 32'h9000, r);
    ahb(1'b1, REG_CMD, {29'h0, OP_PROG}, r);
    repeat (1200) @(posedge hclk);
    chk({31'h0, pump_on}, 32'h1);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk({31'h0, pump_on}, 32'h0);
    hresetn <= 1'b1;
    op(OP_PROG, PROT_ADDR, 8'h01, 1'b0, b);
    op(OP_PROG, ps(8'h01), 8'h00, 1'b1, b);
    op(OP_PROG, ps(8'h01) - 16'h1, 8'h5a, 1'b0, b);
    rdb(ps(8'h01) - 16'h1, 8'h5a);
    op(OP_PAGE, PROT_ADDR, 8'h00, 1'b1, b);
    op(OP_MASS, 16'h8000, 8'h00, 1'b1, b);
    test_hv <= 1'b1;
    op(OP_MASS, 16'h8000, 8'h00, 1'b0, b);
    rdb(PROT_ADDR, ERASED);
    rdb(ps(8'h01) - 16'h1, ERASED);
    op(OP_PROG, PROT_ADDR, BPR_ALL, 1'b0, b);
    test_hv <= 1'b0;
    op(OP_PROG, 16'h8000, 8'h00, 1'b1, b);
    op(OP_STOP, 16'h8000, 8'h00, 1'b0, b);
    chk({31'h0, standby}, 32'h1);
    rdb(16'h8000, ERASED);
    chk({31'h0, standby}, 32'h0);
    end_sim();
  end
  initial begin
    #950000;
    err_total++;
    end_sim();
  end
endmodule // flash_program_erase_ctrl_bench
